// ===== stc_pkg.sv
// constants shared by the standard timer compare core
package stc_pkg;

	localparam int          STC_CNT_W     = 10;
	localparam int          STC_AW        = 3;
	localparam logic [9:0]  STC_CNT_MAX   = 10'h3ff;
	localparam logic [9:0]  STC_CNT_RST   = 10'h000;
	localparam logic [7:0]  STC_BYTE_RST  = 8'h00;

	// register indices on the plain port
	localparam logic [2:0]  STC_ADDR_C0   = 3'h0;
	localparam logic [2:0]  STC_ADDR_C1   = 3'h1;
	localparam logic [2:0]  STC_ADDR_CLO  = 3'h2;
	localparam logic [2:0]  STC_ADDR_CHI  = 3'h3;
	localparam logic [2:0]  STC_ADDR_ALO  = 3'h4;
	localparam logic [2:0]  STC_ADDR_AHI  = 3'h5;
	localparam logic [2:0]  STC_ADDR_STAT = 3'h6;

	// control zero fields
	localparam int          STC_C0_ON     = 3;
	localparam int          STC_C0_RP     = 0;
	// timer_control_one fields
	localparam int          STC_C1_MODE   = 6;
	localparam int          STC_C1_IO     = 4;
	localparam int          STC_C1_OC     = 3;
	localparam int          STC_C1_POL    = 2;
	localparam int          STC_C1_DPX    = 1;
	localparam int          STC_C1_CCLR   = 0;
	// status fields, write one to clear
	localparam int          STC_ST_AF     = 0;
	localparam int          STC_ST_PF     = 1;

	// operating modes
	localparam logic [1:0]  STC_MODE_CMP  = 2'h0;
	localparam logic [1:0]  STC_MODE_CAP  = 2'h1;
	localparam logic [1:0]  STC_MODE_PWM  = 2'h2;
	localparam logic [1:0]  STC_MODE_TC   = 2'h3;

	// pin function codes per mode
	localparam logic [1:0]  STC_IO_KEEP   = 2'h0;
	localparam logic [1:0]  STC_IO_LOW    = 2'h1;
	localparam logic [1:0]  STC_IO_HIGH   = 2'h2;
	localparam logic [1:0]  STC_IO_TOGGLE = 2'h3;
	localparam logic [1:0]  STC_IO_INACT  = 2'h0;
	localparam logic [1:0]  STC_IO_ACT    = 2'h1;
	localparam logic [1:0]  STC_IO_PWM    = 2'h2;
	localparam logic [1:0]  STC_IO_PULSE  = 2'h3;
	localparam logic [1:0]  STC_IO_RISE   = 2'h0;
	localparam logic [1:0]  STC_IO_FALL   = 2'h1;
	localparam logic [1:0]  STC_IO_BOTH   = 2'h2;

	localparam int          STC_P_SHIFT   = 7;

endpackage : stc_pkg

// ===== stc_edge_sync.sv
// two-stage synchroniser and edge detector for the capture pin
`timescale 1ns/1ps
module stc_edge_sync (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic pinIn,
	output logic      riseEvt,
	output logic      fallEvt
);

	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pinIn;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign riseEvt = sync_r & ~last_r;
	assign fallEvt = ~sync_r & last_r;

endmodule : stc_edge_sync

// ===== stc_core.sv
// standard timer compare core: counter, comparators, pin and registers
//
// Contract
// - compare mode A match: code 00 keep, 01 low, 10 high, 11 toggle.
// - pwm codes: 00 inactive, 01 active, 10 waveform, 11 single pulse.
// - capture codes: 00 rising, 01 falling, 10 both, 11 disabled.
// - match asking for the level already shown changes nothing visible.
// - counter-on rising edge restores the pin to its initial level.
// - initial level bit sets compare start level and pwm active level.
// - single pulse takes initial level at counter-on rise; unused in timer mode.
// - invert bit inverts the pin; ignored in timer/counter mode.
// - swap bit 0: P period, A duty; 1: roles exchanged.
// - clear source 1 clears on A; 0 clears on P or overflow.
// - clear source bit ignored in pwm, single pulse and capture.
// - counter read as low byte and two-bit high byte, rest zero.
// - compare-A held as low byte and two-bit high byte, rest zero.
// - mode 00 is compare output; clears on overflow, A or P.
// - compare mode, clear source low: both flags raised on matches.
// - compare mode, clear source high: only A flag, never P flag.
// - compare-A zero: counter runs to 3FF, overflows, no A flag.
// - pin changes only on A match flag; P match leaves it.
// - mode 11 counts like compare mode, pin left unused.
// - counter-on rise zeroes counter; fall stops and holds value.
// - compare-P meets counter bits 9..7; zero means 1024-clock period.
// - high byte read latches low byte; low read returns buffer.
// - low write buffered; high write loads both bytes at once.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
module stc_core
	import stc_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [STC_AW-1:0] addr,
	input  wire logic [7:0]        wrData,
	input  wire logic              wrEn,
	input  wire logic              rdEn,
	output logic      [7:0]        rdData,
	input  wire logic              capturePin,
	output logic                   timerOutPin,
	output logic                   timerOutEn
);

	function automatic logic [7:0] hiByte(input logic [9:0] v);
		hiByte = {6'h00, v[9:8]};
	endfunction : hiByte

	////////////////////////////////////////////////////////////////////
	// state and decoded fields

	logic [7:0] ctrl0_r;
	logic [7:0] ctrl1_r;
	logic [9:0] cnt_r;
	logic [9:0] cntNxt;
	logic [9:0] compare_a_value_r;
	logic [7:0] wrBuf_r;
	logic [7:0] rdBuf_r;
	logic [7:0] rdData_r;
	logic [7:0] rdNxt;
	logic       aFlag_r;
	logic       pFlag_r;
	logic       onPrev_r;
	logic       cmpLvl_r;
	logic       pinOut_r;
	logic       pinEn_r;
	logic       pinNxt;

	logic       on;
	logic [2:0] rp;
	logic [1:0] mode;
	logic [1:0] io;
	logic       oc;
	logic       pol;
	logic       dpx;
	logic       cclr;
	logic       onRise;
	logic       running;
	logic [9:0] cntInc;
	logic       aMatch;
	logic       aPeriod;
	logic       pMatch;
	logic       cntClr;
	logic       cmpLike;
	logic       capMode;
	logic       spMode;
	logic       pwmMode;
	logic       capRise;
	logic       capFall;
	logic       capHit;
	logic       aSet;
	logic       pSet;
	logic [10:0] duty;
	logic       pwmAct;
	logic       wrC0;
	logic       wrStat;

	assign on      = ctrl0_r[STC_C0_ON];
	assign rp      = ctrl0_r[STC_C0_RP +: 3];
	assign mode    = ctrl1_r[STC_C1_MODE +: 2];
	assign io      = ctrl1_r[STC_C1_IO +: 2];
	assign oc      = ctrl1_r[STC_C1_OC];
	assign pol     = ctrl1_r[STC_C1_POL];
	assign dpx     = ctrl1_r[STC_C1_DPX];
	assign cclr    = ctrl1_r[STC_C1_CCLR];
	assign wrC0    = wrEn && addr == STC_ADDR_C0;
	assign wrStat  = wrEn && addr == STC_ADDR_STAT;

	assign onRise  = on & ~onPrev_r;
	assign running = on & ~onRise;
	assign cmpLike = mode == STC_MODE_CMP || mode == STC_MODE_TC;
	assign capMode = mode == STC_MODE_CAP;
	assign spMode  = mode == STC_MODE_PWM && io == STC_IO_PULSE;
	assign pwmMode = mode == STC_MODE_PWM && !spMode;

	////////////////////////////////////////////////////////////////////
	// comparators and clear selection

	assign cntInc = cnt_r + 10'h001;
	// a zero compare-A never matches, so the counter wraps at the top
	assign aMatch = running && compare_a_value_r != STC_CNT_RST
		&& cnt_r == compare_a_value_r;
	// P matches where the next count reaches rp*128; rp zero is overflow
	assign pMatch = running && cntInc[9:STC_P_SHIFT] == rp
		&& cntInc[STC_P_SHIFT-1:0] == 7'h00;
	// pwm period from A clears one count early so the period equals A
	assign aPeriod = running && compare_a_value_r != STC_CNT_RST
		&& cntInc == compare_a_value_r;

	always_comb begin
		cntClr = 1'b0;
		case (1'b1)
			cmpLike: cntClr = cclr ? aMatch : pMatch;
			pwmMode: cntClr = dpx ? aPeriod : pMatch;
			capMode: cntClr = pMatch;
			default: cntClr = 1'b0;
		endcase
	end

	assign capHit = capMode && running && (
		(io == STC_IO_RISE && capRise) ||
		(io == STC_IO_FALL && capFall) ||
		(io == STC_IO_BOTH && (capRise || capFall)));

	assign aSet = capMode ? capHit
		: (pwmMode && dpx) ? aPeriod : aMatch;
	assign pSet = pMatch && ((cmpLike && !cclr)
		|| pwmMode || capMode);

	stc_edge_sync u_capSync (
		.clock   (clock),
		.rst_n   (rst_n),
		.pinIn   (capturePin),
		.riseEvt (capRise),
		.fallEvt (capFall)
	);

	////////////////////////////////////////////////////////////////////
	// counter

	always_comb begin
		cntNxt = cnt_r;
		if (onRise)
			cntNxt = STC_CNT_RST;
		else if (on && cntClr)
			cntNxt = STC_CNT_RST;
		else if (on)
			cntNxt = cntInc;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			cnt_r <= STC_CNT_RST;
		else
			cnt_r <= cntNxt;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			onPrev_r <= 1'b0;
		else
			onPrev_r <= on;
	end

	////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl0_r <= STC_BYTE_RST;
		end else begin
			if (wrC0)
				ctrl0_r <= wrData;
			// a single pulse ends when A matches
			if (spMode && aMatch)
				ctrl0_r[STC_C0_ON] <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			ctrl1_r <= STC_BYTE_RST;
		else if (wrEn && addr == STC_ADDR_C1)
			ctrl1_r <= wrData;
	end

	////////////////////////////////////////////////////////////////////
	// compare-A pair with write buffer; capture overrides

	always_ff @(posedge clock) begin
		if (!rst_n)
			wrBuf_r <= STC_BYTE_RST;
		else if (wrEn && addr == STC_ADDR_ALO)
			wrBuf_r <= wrData;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			compare_a_value_r <= STC_CNT_RST;
		else if (capHit)
			compare_a_value_r <= cnt_r;
		else if (wrEn && addr == STC_ADDR_AHI)
			compare_a_value_r <= {wrData[1:0], wrBuf_r};
	end

	////////////////////////////////////////////////////////////////////
	// sticky flags, set beats clear

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			aFlag_r <= 1'b0;
			pFlag_r <= 1'b0;
		end else begin
			aFlag_r <= aSet
				| (aFlag_r & ~(wrStat & wrData[STC_ST_AF]));
			pFlag_r <= pSet
				| (pFlag_r & ~(wrStat & wrData[STC_ST_PF]));
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path: high byte read latches the low byte

	always_ff @(posedge clock) begin
		if (!rst_n)
			rdBuf_r <= STC_BYTE_RST;
		else if (rdEn && addr == STC_ADDR_CHI)
			rdBuf_r <= cnt_r[7:0];
		else if (rdEn && addr == STC_ADDR_AHI)
			rdBuf_r <= compare_a_value_r[7:0];
	end

	always_comb begin
		case (addr)
			STC_ADDR_C0:   rdNxt = ctrl0_r;
			STC_ADDR_C1:   rdNxt = ctrl1_r;
			STC_ADDR_CLO:  rdNxt = rdBuf_r;
			STC_ADDR_CHI:  rdNxt = hiByte(cnt_r);
			STC_ADDR_ALO:  rdNxt = rdBuf_r;
			STC_ADDR_AHI:  rdNxt = hiByte(compare_a_value_r);
			STC_ADDR_STAT: rdNxt = {6'h00, pFlag_r, aFlag_r};
			default:       rdNxt = STC_BYTE_RST;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			rdData_r <= STC_BYTE_RST;
		else
			rdData_r <= rdEn ? rdNxt : STC_BYTE_RST;
	end

	assign rdData = rdData_r;

	////////////////////////////////////////////////////////////////////
	// output pin

	// compare level: only A matches move it, on rise restores it
	always_ff @(posedge clock) begin
		if (!rst_n)
			cmpLvl_r <= 1'b0;
		else if (onRise)
			cmpLvl_r <= oc;
		else if (mode == STC_MODE_CMP && aMatch) begin
			case (io)
				STC_IO_LOW:    cmpLvl_r <= 1'b0;
				STC_IO_HIGH:   cmpLvl_r <= 1'b1;
				STC_IO_TOGGLE: cmpLvl_r <= ~cmpLvl_r;
				default:       cmpLvl_r <= cmpLvl_r;
			endcase
		end
	end

	// duty from A, or from P with 1024 for a zero code
	assign duty   = dpx ? {rp == 3'h0, rp, 7'h00}
		: {1'b0, compare_a_value_r};
	assign pwmAct = on && {1'b0, cnt_r} < duty;

	always_comb begin
		pinNxt = 1'b0;
		if (mode == STC_MODE_CMP)
			pinNxt = cmpLvl_r;
		else if (mode == STC_MODE_PWM) begin
			case (io)
				STC_IO_INACT: pinNxt = ~oc;
				STC_IO_ACT:   pinNxt = oc;
				STC_IO_PWM:   pinNxt = pwmAct ? oc : ~oc;
				default:      pinNxt = on ? oc : ~oc;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinOut_r <= 1'b0;
			pinEn_r  <= 1'b0;
		end else begin
			pinEn_r  <= mode == STC_MODE_CMP
				|| mode == STC_MODE_PWM;
			pinOut_r <= pinNxt ^ (pol && mode != STC_MODE_TC);
		end
	end

	assign timerOutPin = pinOut_r;
	assign timerOutEn  = pinEn_r;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	logic [7:0] cntLo;
	logic [1:0] wrLoBits;
	assign cntLo    = cnt_r[7:0];
	assign wrLoBits = wrData[1:0];

	sequence s_hiRead;
		rdEn && addr == STC_ADDR_CHI;
	endsequence
	sequence s_loRead;
		rdEn && addr == STC_ADDR_CLO;
	endsequence
	sequence s_aLoWr;
		wrEn && addr == STC_ADDR_ALO && !capMode;
	endsequence
	sequence s_aHiWr;
		wrEn && addr == STC_ADDR_AHI && !capMode && !capHit;
	endsequence
	sequence s_setHigh;
		mode == STC_MODE_CMP && io == STC_IO_HIGH && aMatch && !pol;
	endsequence

	a_on_rise_zero: assert property (onRise |=> cnt_r == STC_CNT_RST)
		else $error("counter not zeroed on start");
	a_off_holds: assert property (
		!on && !wrC0 |=> $stable(cnt_r))
		else $error("stopped counter moved");
	a_cclr_no_pflag: assert property (
		cmpLike && cclr |-> !pSet)
		else $error("P flag raised with clear source high");
	a_azero_no_flag: assert property (
		!capMode && compare_a_value_r == STC_CNT_RST |-> !aSet)
		else $error("A flag raised with zero compare value");
	a_pmatch_clear: assert property (
		cmpLike && !cclr && pMatch && !wrC0 |=> cnt_r == STC_CNT_RST)
		else $error("P match did not clear counter");
	a_pin_goes_high: assert property (
		s_setHigh ##1 (mode == STC_MODE_CMP && !onRise && !pol)
		|=> timerOutPin)
		else $error("pin not driven high on A match");
	a_flag_sticky: assert property (
		aFlag_r && !(wrStat && wrData[STC_ST_AF]) |=> aFlag_r)
		else $error("A flag dropped without clear");
	a_hi_read_buf: assert property (
		s_hiRead ##1 s_loRead |=> rdData == $past(cntLo, 2))
		else $error("low byte not from read buffer");
	a_pair_write: assert property (
		s_aLoWr ##1 s_aHiWr
		|=> compare_a_value_r == {$past(wrLoBits), $past(wrData, 2)})
		else $error("compare-A pair write wrong");
	a_tc_pin_off: assert property (
		mode == STC_MODE_TC ##1 mode == STC_MODE_TC |-> !timerOutEn)
		else $error("pin driven in timer/counter mode");

endmodule : stc_core

// ===== stc_pin_model.sv
// far-side model: drives the capture pin and resolves the output pad
`timescale 1ns/1ps
module stc_pin_model (
	input  wire logic clock,
	input  wire logic pinReq,
	input  wire logic timerOutPin,
	input  wire logic timerOutEn,
	output logic      capturePin,
	output logic      padLevel
);
	// the pad has a pull-up, so a released pin reads high
	assign padLevel = timerOutEn ? timerOutPin : 1'b1;
	initial capturePin = 1'b0;
	// edges land mid-cycle, unrelated to the sampling edge
	always @(posedge clock) capturePin <= #37 pinReq;
endmodule : stc_pin_model

// ===== standard_timer_compare_core_tb_top.sv
// self-checking bench for the standard timer compare core
`timescale 1ns/1ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module standard_timer_compare_core_tb_top
	import stc_pkg::*;
();
	typedef struct packed {logic [7:0] exp; logic [7:0] msk;} stc_note_t;
	logic              clock, rst_n, wrEn, rdEn, pinReq, rdSeen;
	logic              timerOutPin, timerOutEn, capturePin, padLevel;
	logic [STC_AW-1:0] addr;
	logic [7:0]        wrData, rdData, rdLast, rdPrev;
	logic [31:0]       seed;
	int                errors, numChecks, cycles;
	stc_note_t         notes[$];
	stc_note_t         cur;

	stc_core i_dut (.clock(clock), .rst_n(rst_n), .addr(addr),
		.wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
		.capturePin(capturePin), .timerOutPin(timerOutPin),
		.timerOutEn(timerOutEn));
	stc_pin_model i_pins (.clock(clock), .pinReq(pinReq),
		.timerOutPin(timerOutPin), .timerOutEn(timerOutEn),
		.capturePin(capturePin), .padLevel(padLevel));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		if (rdSeen) begin
			cur = notes.pop_front();
			`CHK(rdData & cur.msk, cur.exp)
			rdPrev <= rdLast;
			rdLast <= rdData;
		end
		rdSeen <= rdEn;
		cycles++;
		if (cycles == 20000) begin
			errors++;
			printVerdict();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic printVerdict();
		$display("checks %0d errors %0d", numChecks, errors);
		if (errors == 0 && numChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : printVerdict

	function automatic logic [31:0] nextRand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : nextRand

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		wrEn   <= 1'b1;
		addr   <= a;
		wrData <= d;
		@(posedge clock);
		wrEn   <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m);
		notes.push_back('{e, m});
		@(posedge clock);
		rdEn <= 1'b1;
		addr <= a;
		@(posedge clock);
		rdEn <= 1'b0;
	endtask : rd

	// high byte first; the value is taken at the high-byte read
	task automatic rdPair(input logic [2:0] hi, output logic [9:0] v);
		notes.push_back('{8'h00, 8'hfc});
		notes.push_back('{8'h00, 8'h00});
		@(posedge clock);
		rdEn <= 1'b1;
		addr <= hi;
		@(posedge clock);
		addr <= hi - 3'h1;
		@(posedge clock);
		rdEn <= 1'b0;
		@(posedge clock);
		#1 v = {rdPrev[1:0], rdLast};
	endtask : rdPair

	// low then high byte on back-to-back strobes
	task automatic setA(input logic [9:0] v);
		@(posedge clock);
		wrEn   <= 1'b1;
		addr   <= STC_ADDR_ALO;
		wrData <= v[7:0];
		@(posedge clock);
		addr   <= STC_ADDR_AHI;
		wrData <= {6'h00, v[9:8]};
		@(posedge clock);
		wrEn   <= 1'b0;
	endtask : setA

	// control is changed only while the counter is off
	task automatic start(input logic [7:0] c1, input logic [2:0] cp,
		input logic [9:0] a);
		wr(STC_ADDR_C0, 8'h00);
		setA(a);
		wr(STC_ADDR_C1, c1);
		wr(STC_ADDR_C0, {5'h01, cp});
	endtask : start

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [9:0] v0;
		logic [9:0] v1;
		logic       lvl;
		integer     n;
		{rst_n, wrEn, rdEn, pinReq, rdSeen, addr, wrData} = '0;
		{rdLast, rdPrev} = '0;
		seed = 32'd40;
		errors = 0;
		numChecks = 0;
		cycles = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) rd(i[2:0], 8'h00, 8'hff);
		// timer mode: free count, then stop and hold
		start(8'hc0, 3'h0, 10'd0);
		rdPair(STC_ADDR_CHI, v0);
		repeat (6) @(posedge clock);
		rdPair(STC_ADDR_CHI, v1);
		`CHK(v1 - v0, 10'd10)
		`CHK(padLevel, 1'b1)
		wr(STC_ADDR_C0, 8'h00);
		rdPair(STC_ADDR_CHI, v0);
		repeat (5) @(posedge clock);
		rdPair(STC_ADDR_CHI, v1);
		`CHK(v1, v0)
		v0 = 10'(nextRand());
		setA(v0);
		wr(STC_ADDR_ALO, ~v0[7:0]);
		rdPair(STC_ADDR_AHI, v1);
		`CHK(v1, v0)
		wr(STC_ADDR_STAT, 8'h03);
		// compare mode pin actions over every code, level and invert
		for (int k = 0; k < 16; k++) begin
			start({2'b00, k[3:0], 2'b01}, 3'h1, 10'd20);
			repeat (4) @(posedge clock);
			`CHK(timerOutPin, k[1] ^ k[0])
			repeat (30) @(posedge clock);
			lvl = (k[3:2] == 2'd0) ? k[1] : (k[3:2] == 2'd3) ? ~k[1] : k[3];
			`CHK(timerOutPin, lvl ^ k[0])
			`CHK(timerOutEn, 1'b1)
		end
		rd(STC_ADDR_STAT, 8'h01, 8'h03);
		start(8'h00, 3'h1, 10'd20);
		wr(STC_ADDR_STAT, 8'h03);
		repeat (300) @(posedge clock);
		rd(STC_ADDR_STAT, 8'h03, 8'h03);
		rdPair(STC_ADDR_CHI, v0);
		`CHK(v0 < 10'd128, 1'b1)
		wr(STC_ADDR_C0, 8'h00);
		wr(STC_ADDR_STAT, 8'h03);
		rd(STC_ADDR_STAT, 8'h00, 8'h03);
		// zero compare-A in timer/counter mode: counter wraps, no A flag, pin off
		start(8'hc1, 3'h0, 10'd0);
		wr(STC_ADDR_STAT, 8'h03);
		repeat (1100) @(posedge clock);
		rd(STC_ADDR_STAT, 8'h00, 8'h01);
		`CHK(timerOutEn, 1'b0)
		// capture edge selection
		for (int k = 0; k < 4; k++) begin
			start({2'b01, k[1:0], 4'h0}, 3'h0, 10'd0);
			repeat (20) @(posedge clock);
			pinReq <= 1'b1;
			repeat (100) @(posedge clock);
			pinReq <= 1'b0;
			repeat (10) @(posedge clock);
			rdPair(STC_ADDR_AHI, v0);
			n = (v0 == 10'd0) ? 3 : (v0 < 10'd60) ? 0 : 1;
			`CHK(n, (k == 0) ? 0 : (k == 3) ? 3 : 1)
		end
		// forced pwm levels
		for (int k = 0; k < 4; k++) begin
			start({3'b100, k[0], k[1], 3'h0}, 3'h1, 10'd32);
			repeat (5) @(posedge clock);
			`CHK(timerOutPin, k[0] ? k[1] : ~k[1])
		end
		// pwm waveform, period and duty swapped by the swap bit
		for (int k = 0; k < 2; k++) begin
			start({6'b101010, k[0], 1'b0}, 3'h1, k ? 10'd256 : 10'd32);
			repeat (10) @(posedge clock);
			n = 0;
			repeat (k ? 256 : 128) begin
				@(posedge clock);
				n += timerOutPin;
			end
			`CHK(n, k ? 128 : 32)
		end
		start(8'hb8, 3'h0, 10'd50);
		repeat (10) @(posedge clock);
		`CHK(timerOutPin, 1'b1)
		repeat (60) @(posedge clock);
		`CHK(timerOutPin, 1'b0)
		rd(STC_ADDR_C0, 8'h00, 8'h08);
		repeat (3) @(posedge clock);
		printVerdict();
	end
endmodule : standard_timer_compare_core_tb_top
